// file: src/ccir_ctrl.sv
// Contract
// R1: Unlock bit 6 gates bit-timing register writes.
// R2: Bit 3 gates bus-off and warning requests.
// R3: Bit 2 gates receive, send, error-code requests.
// R4: Every valid received frame raises receive request; the code raises it only while bit 2 is set.
// R5: Interrupt needs global gate and source enable.
// R6: Gate clear still updates pending code.
// R7: Init bit isolates; no new transfer starts.
// R8: Reset sets init; control resets to 01H.
// R9: After init clear wait 11 recessive bits.
// R10: Sleep instruction aborts sending at once.
// R11: Error counter at 256 forces init, bus-off.
// R12: Bus-off recovery clears counters, waits 128 idles.
// R13: Software locks single objects, not whole controller; the code has no object lock.
// R14: Mask one demands match, zero ignores bit.
// R15: Mask bits placed in four byte groups.
// R16: Mask at 1E08H-1E0BH, byte/word/dword access.
// R17: Mask keeps its value across reset.
// R18: Code 00H none, 01H status, top priority.
// R19: Object 15 is 02H, objects 1-14 03H-10H.
// R20: Object request sets its pending bit-pair.
// R21: Reception rewrites length field bits 7:4.
// R22: Config bit 3 selects receive or send.
// R23: Config bit 2 selects standard or extended id.
// R24: Code register ignores writes, follows pending sources.
`include "ccir_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccir_ctrl
	import ccir_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire ccir_bus_t          bus,
	output logic        [31:0]      rdata,
	input  wire ccir_evt_t          evt,
	input  wire logic   [8:0]       tec,
	input  wire logic   [8:0]       rec,
	input  wire logic               status_ack,
	input  wire logic               sleep_instruction,
	input  wire logic   [14:0]      obj_rx_done,
	input  wire logic   [14:0]      obj_tx_done,
	input  wire logic   [3:0]       obj_rx_len,
	input  wire logic   [28:0]      rx_id,
	input  wire logic   [28:0]      obj_id,
	output logic                    id_accept,
	output logic        [28:0]      id_match_mask,
	output logic                    timing_write_unlock,
	output logic                    timing_write_ok,
	output logic                    bus_isolated,
	output logic                    start_allowed,
	output logic                    send_abort,
	output logic                    err_cnt_clear,
	output logic                    irq,
	output logic        [14:0]      obj_is_send,
	output logic        [14:0]      obj_long_id
);

	logic        [7:0]  ctrl_r;
	logic        [31:0] mask_r;
	logic        [7:0]  code_r;
	logic        [31:0] rdata_r;
	logic        [3:0]  con0_r [`CCIR_NOBJ];
	logic        [7:0]  cfg_r  [`CCIR_NOBJ];
	logic        [14:0] pnd_v;
	logic        [14:0] object_receive_irq_enable_v;
	logic        [14:0] object_send_irq_enable_v;
	logic               stat_pend_r;
	logic               bus_off_r;
	logic               err_clr_r;
	ccir_state_t        state_r;
	logic        [3:0]  bit_cnt_r;
	logic        [7:0]  run_cnt_r;
	logic        [7:0]  need;
	logic               boff_evt;
	logic               stat_set;
	logic        [14:0] obj_ev;
	logic        [31:0] rd_word;

	function automatic logic [2:0] span(input logic [1:0] s);
		unique case (s)
			2'h0: span = 3'h1;
			2'h1: span = 3'h2;
			default: span = 3'h4;
		endcase
	endfunction : span

	function automatic logic byte_hit(input ccir_bus_t b, input logic [15:0] t);
		logic [15:0] d;
		d = t - b.addr;
		byte_hit = b.wr && (d < {13'h0000, span(b.size)});
	endfunction : byte_hit

	function automatic logic [7:0] byte_of(input ccir_bus_t b, input logic [15:0] t);
		logic [15:0] d;
		d = t - b.addr;
		byte_of = b.wdata[{d[1:0], 3'h0} +: 8];
	endfunction : byte_of

	function automatic logic [15:0] obj_addr(input logic [15:0] base, input int n);
		obj_addr = base + 16'(n) * `CCIR_OBJ_STRIDE;
	endfunction : obj_addr

	// True bit high, complement low: 10 sets, 01 clears, others leave the bit.
	function automatic logic [3:0] pairs(input logic [3:0] cur, input logic [7:0] w);
		pairs = cur;
		for (int i = 0; i < 4; i++) begin
			if (w[2*i +: 2] == 2'h2) begin
				pairs[i] = 1'b1;
			end else if (w[2*i +: 2] == 2'h1) begin
				pairs[i] = 1'b0;
			end
		end
	endfunction : pairs

	function automatic logic [7:0] expand(input logic [3:0] c);
		expand = 8'h00;
		for (int i = 0; i < 4; i++) begin
			expand[2*i +: 2] = {c[i], ~c[i]};
		end
	endfunction : expand

	function automatic logic [7:0] prio(input logic st, input logic [14:0] p);
		prio = `CCIR_CODE_NONE;
		for (int n = 13; n >= 0; n--) begin
			if (p[n]) begin
				prio = `CCIR_CODE_OBJ1 + 8'(n); // R19
			end
		end
		if (p[14]) begin
			prio = `CCIR_CODE_OBJ15; // R19
		end
		if (st) begin
			prio = `CCIR_CODE_STAT; // R18
		end
	endfunction : prio

	assign boff_evt = (tec[8] || rec[8]) && !bus_off_r;
	assign need = bus_off_r ? `CCIR_IDLE_RUNS : `CCIR_IDLE_ONCE;

	// Software writes a zero into the init bit, but a bus-off in the same cycle wins.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `CCIR_CTRL_RST; // R8
		end else begin
			if (byte_hit(bus, `CCIR_CTRL_ADDR)) begin
				ctrl_r <= byte_of(bus, `CCIR_CTRL_ADDR) & `CCIR_CTRL_WMASK;
			end
			if (boff_evt) begin
				ctrl_r[`CCIR_B_INIT] <= 1'b1; // R11
			end
		end
	end

	assign timing_write_unlock = ctrl_r[`CCIR_B_UNLOCK];
	assign timing_write_ok = (byte_hit(bus, `CCIR_BT0_ADDR) || byte_hit(bus, `CCIR_BT1_ADDR))
		&& ctrl_r[`CCIR_B_UNLOCK]; // R1

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_off_r <= 1'b0;
		end else if (boff_evt) begin
			bus_off_r <= 1'b1; // R11
		end else if (state_r == ST_RUN) begin
			bus_off_r <= 1'b0;
		end
	end

	// Idle runs only count unbroken recessive bits; a dominant bit restarts the run.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_ISOL;
			bit_cnt_r <= 4'h0;
			run_cnt_r <= 8'h00;
		end else if (ctrl_r[`CCIR_B_INIT]) begin
			state_r <= ST_ISOL; // R7
		end else begin
			unique case (state_r)
				ST_ISOL: begin
					state_r <= ST_WAIT;
					bit_cnt_r <= 4'h0;
					run_cnt_r <= 8'h00;
				end
				ST_WAIT: begin
					if (evt.bit_tick) begin
						if (!evt.rx_bit) begin
							bit_cnt_r <= 4'h0;
						end else if (bit_cnt_r == `CCIR_IDLE_BITS - 4'h1) begin // R9
							bit_cnt_r <= 4'h0;
							if (run_cnt_r == need - 8'h01) begin // R12
								state_r <= ST_RUN;
							end else begin
								run_cnt_r <= run_cnt_r + 8'h01;
							end
						end else begin
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				ST_RUN: begin
					state_r <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			err_clr_r <= 1'b0;
		end else begin
			err_clr_r <= (state_r == ST_ISOL) && !ctrl_r[`CCIR_B_INIT] && bus_off_r; // R12
		end
	end

	assign err_cnt_clear = err_clr_r;
	assign bus_isolated = ctrl_r[`CCIR_B_INIT]; // R7
	assign start_allowed = (state_r == ST_RUN) && !ctrl_r[`CCIR_B_INIT]; // R7
	assign send_abort = sleep_instruction; // R10

	assign stat_set = (ctrl_r[`CCIR_B_STATIE] && (evt.rx_ok || evt.tx_ok || evt.lec_chg)) // R3 R4
		|| (ctrl_r[`CCIR_B_ERRIE] && (evt.warn_rise || boff_evt)); // R2

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_pend_r <= 1'b0;
		end else if (stat_set) begin
			stat_pend_r <= 1'b1;
		end else if (status_ack) begin
			stat_pend_r <= 1'b0;
		end
	end

	always_comb begin
		for (int n = 0; n < `CCIR_NOBJ; n++) begin
			pnd_v[n] = con0_r[n][0];
			object_receive_irq_enable_v[n] = con0_r[n][1];
			object_send_irq_enable_v[n] = con0_r[n][2];
			obj_is_send[n] = cfg_r[n][`CCIR_CFG_DIR]; // R22
			obj_long_id[n] = cfg_r[n][`CCIR_CFG_XTD]; // R23
		end
	end

	assign obj_ev = (obj_rx_done & object_receive_irq_enable_v) | (obj_tx_done & object_send_irq_enable_v);

	// Pending pairs are cleared at reset so the code register never starts unknown.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int n = 0; n < `CCIR_NOBJ; n++) begin
				con0_r[n] <= 4'h0;
			end
		end else begin
			for (int n = 0; n < `CCIR_NOBJ; n++) begin
				if (byte_hit(bus, obj_addr(`CCIR_CON0_BASE, n))) begin
					con0_r[n] <= pairs(con0_r[n], byte_of(bus, obj_addr(`CCIR_CON0_BASE, n)));
				end
				if (obj_ev[n]) begin
					con0_r[n][0] <= 1'b1; // R20
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int n = 0; n < `CCIR_NOBJ; n++) begin
			if (byte_hit(bus, obj_addr(`CCIR_CFG_BASE, n))) begin
				cfg_r[n] <= byte_of(bus, obj_addr(`CCIR_CFG_BASE, n)) & `CCIR_CFG_WMASK;
			end
			if (obj_rx_done[n]) begin
				cfg_r[n][7:4] <= obj_rx_len; // R21
			end
		end
	end

	// No reset here: the mask survives a reset with its last written value.
	for (genvar i = 0; i < 4; i++) begin : g_mask
		always_ff @(posedge ref_clk) begin
			if (byte_hit(bus, `CCIR_MASK_ADDR + 16'(i))) begin // R16 R17
				mask_r[8*i +: 8] <= byte_of(bus, `CCIR_MASK_ADDR + 16'(i))
					& 8'(`CCIR_MASK_VALID >> (8 * i)); // R15
			end
		end
	end

	assign id_match_mask = {mask_r[7:0], mask_r[15:8], mask_r[23:16], mask_r[31:27]}; // R15
	assign id_accept = ((rx_id ^ obj_id) & id_match_mask) == 29'h00000000; // R14

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			code_r <= `CCIR_CODE_NONE;
		end else begin
			code_r <= prio(stat_pend_r, pnd_v); // R6 R24
		end
	end

	assign irq = ctrl_r[`CCIR_B_GATE] && (code_r != `CCIR_CODE_NONE); // R5

	for (genvar k = 0; k < 4; k++) begin : g_rd
		logic [7:0] lane;
		always_comb begin
			logic [15:0] t;
			t = bus.addr + 16'(k);
			lane = 8'h00;
			if (3'(k) < span(bus.size)) begin
				if (t == `CCIR_CTRL_ADDR) begin
					lane = ctrl_r;
				end
				if (t[15:2] == `CCIR_MASK_ADDR >> 2) begin
					lane = mask_r[{t[1:0], 3'h0} +: 8];
				end
				if (t == `CCIR_CODE_ADDR) begin
					lane = code_r;
				end
				for (int n = 0; n < `CCIR_NOBJ; n++) begin
					if (t == obj_addr(`CCIR_CON0_BASE, n)) begin
						lane = expand(con0_r[n]);
					end
					if (t == obj_addr(`CCIR_CFG_BASE, n)) begin
						lane = cfg_r[n];
					end
				end
			end
		end
	end

	assign rd_word = {g_rd[3].lane, g_rd[2].lane, g_rd[1].lane, g_rd[0].lane};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= bus.rd ? rd_word : 32'h00000000;
		end
	end

	assign rdata = rdata_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_boff_leave;
		(state_r == ST_ISOL) && bus_off_r && !ctrl_r[`CCIR_B_INIT];
	endsequence

	sequence s_clear_pulse;
		err_cnt_clear ##1 !err_cnt_clear;
	endsequence

	a_unlock_gate: assert property ((byte_hit(bus, `CCIR_BT0_ADDR) && !ctrl_r[`CCIR_B_UNLOCK])
		|-> !timing_write_ok) else $error("timing write passed while locked"); // R1
	a_err_enable: assert property ((evt.warn_rise && ctrl_r[`CCIR_B_ERRIE]) |=> stat_pend_r)
		else $error("warning request lost"); // R2
	a_rx_status: assert property ((evt.rx_ok && ctrl_r[`CCIR_B_STATIE]) |=> stat_pend_r)
		else $error("receive request lost"); // R4
	a_irq_gate: assert property (irq |-> ctrl_r[`CCIR_B_GATE] && code_r != `CCIR_CODE_NONE)
		else $error("interrupt without gate"); // R5
	a_code_ungated: assert property (stat_pend_r |=> code_r == `CCIR_CODE_STAT)
		else $error("status code not shown"); // R6
	a_init_block: assert property (ctrl_r[`CCIR_B_INIT] |-> !start_allowed ##1 state_r != ST_RUN)
		else $error("start allowed while isolated"); // R7
	a_idle_wait: assert property ($rose(state_r == ST_RUN) |->
		$past(bit_cnt_r) == `CCIR_IDLE_BITS - 4'h1 && $past(run_cnt_r) == $past(need) - 8'h01)
		else $error("left idle wait early"); // R9
	a_abort_now: assert property (sleep_instruction |-> send_abort)
		else $error("send not aborted"); // R10
	a_boff_init: assert property (boff_evt |=> ctrl_r[`CCIR_B_INIT] && bus_off_r)
		else $error("bus-off did not isolate"); // R11
	a_boff_clear: assert property (s_boff_leave |=> s_clear_pulse)
		else $error("counter clear pulse wrong"); // R12
	a_code_none: assert property ((!stat_pend_r && pnd_v == 15'h0000) |=> code_r == `CCIR_CODE_NONE)
		else $error("code without source"); // R18
	a_code_obj1: assert property ((!stat_pend_r && !pnd_v[14] && pnd_v[0]) |=> code_r == 8'h03)
		else $error("object one code wrong"); // R19
	a_pnd_set: assert property ((obj_rx_done[0] && object_receive_irq_enable_v[0]) |=> pnd_v[0])
		else $error("pending pair not set"); // R20
	a_len_update: assert property (obj_rx_done[0] |=> cfg_r[0][7:4] == $past(obj_rx_len))
		else $error("length not rewritten"); // R21
	a_mask_rsv: assert property ((bus.rd && bus.addr == `CCIR_MASK_ADDR && bus.size == 2'h2)
		|=> rdata[26:24] == 3'h0) else $error("reserved mask bits set"); // R15

endmodule : ccir_ctrl
`default_nettype wire

// file: src/ccir_pkg.sv
package ccir_pkg;
	typedef enum logic [1:0] {ST_ISOL, ST_WAIT, ST_RUN} ccir_state_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic [1:0]  size;
		logic        wr;
		logic        rd;
	} ccir_bus_t;
	typedef struct packed {
		logic rx_ok;
		logic tx_ok;
		logic lec_chg;
		logic warn_rise;
		logic bit_tick;
		logic rx_bit;
	} ccir_evt_t;
endpackage : ccir_pkg

// file: src/ccir_regs.svh
`ifndef CCIR_REGS_SVH
`define CCIR_REGS_SVH
`define CCIR_CTRL_ADDR  16'h1E00
`define CCIR_MASK_ADDR  16'h1E08
`define CCIR_CODE_ADDR  16'h1E5F
`define CCIR_BT0_ADDR   16'h1E3F
`define CCIR_BT1_ADDR   16'h1E4F
`define CCIR_CON0_BASE  16'h1E10
`define CCIR_CFG_BASE   16'h1E16
`define CCIR_OBJ_STRIDE 16'h0010
`define CCIR_NOBJ       15
`define CCIR_CTRL_RST   8'h01
`define CCIR_CTRL_WMASK 8'h4F
`define CCIR_B_UNLOCK   6
`define CCIR_B_ERRIE    3
`define CCIR_B_STATIE   2
`define CCIR_B_GATE     1
`define CCIR_B_INIT     0
`define CCIR_MASK_VALID 32'hF8FFFFFF
`define CCIR_CFG_WMASK  8'hFC
`define CCIR_CFG_DIR    3
`define CCIR_CFG_XTD    2
`define CCIR_IDLE_BITS  4'hB
`define CCIR_IDLE_ONCE  8'h01
`define CCIR_IDLE_RUNS  8'h80
`define CCIR_CODE_NONE  8'h00
`define CCIR_CODE_STAT  8'h01
`define CCIR_CODE_OBJ15 8'h02
`define CCIR_CODE_OBJ1  8'h03
`endif

// file: testbench/ccir_node.sv
`timescale 1ns/1ps
`default_nettype none
module ccir_node
	import ccir_pkg::*;
(
	input  wire logic       ref_clk,
	output ccir_evt_t       evt,
	output logic      [8:0] tec
);
	initial begin
		evt = '0;
		tec = 9'h000;
	end
	// Between samples the line shows the inverse, so no check leans on a stale bit.
	task automatic bits(input int n, input logic lvl);
		repeat (n) begin
			evt.bit_tick <= 1'b1;
			evt.rx_bit   <= lvl;
			@(posedge ref_clk);
			evt.bit_tick <= 1'b0;
			evt.rx_bit   <= ~lvl;
			@(posedge ref_clk);
		end
	endtask : bits
	task automatic pulse(input int k);
		evt[k] <= 1'b1;
		@(posedge ref_clk);
		evt[k] <= 1'b0;
		@(posedge ref_clk);
	endtask : pulse
	task automatic count(input logic [8:0] v);
		tec <= v;
		@(posedge ref_clk);
	endtask : count
endmodule : ccir_node
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import ccir_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst;
	ccir_bus_t   bus;
	logic [31:0] rdata;
	ccir_evt_t   evt;
	logic [8:0]  tec;
	logic        status_ack;
	logic        sleep_instruction;
	logic [14:0] obj_rx_done;
	logic [3:0]  obj_rx_len;
	logic [28:0] rx_id;
	logic [28:0] obj_id;
	logic        id_accept;
	logic [28:0] id_match_mask;
	logic        timing_write_unlock;
	logic        timing_write_ok;
	logic        bus_isolated;
	logic        start_allowed;
	logic        send_abort;
	logic        err_cnt_clear;
	logic        irq;
	logic [14:0] obj_is_send;
	logic [14:0] obj_long_id;
	logic        ok_seen;
	int          failures = 0;
	int          n_tests = 0;
	int          n_clear = 0;
	int          c0;

	always #5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) if (err_cnt_clear === 1'b1) n_clear++;

	ccir_ctrl i_ccir_ctrl (
		.ref_clk             (ref_clk),
		.rst                 (rst),
		.bus                 (bus),
		.rdata               (rdata),
		.evt                 (evt),
		.tec                 (tec),
		.rec                 (9'h000),
		.status_ack          (status_ack),
		.sleep_instruction   (sleep_instruction),
		.obj_rx_done         (obj_rx_done),
		.obj_tx_done         (15'h0000),
		.obj_rx_len          (obj_rx_len),
		.rx_id               (rx_id),
		.obj_id              (obj_id),
		.id_accept           (id_accept),
		.id_match_mask       (id_match_mask),
		.timing_write_unlock (timing_write_unlock),
		.timing_write_ok     (timing_write_ok),
		.bus_isolated        (bus_isolated),
		.start_allowed       (start_allowed),
		.send_abort          (send_abort),
		.err_cnt_clear       (err_cnt_clear),
		.irq                 (irq),
		.obj_is_send         (obj_is_send),
		.obj_long_id         (obj_long_id)
	);

	ccir_node i_ccir_node (
		.ref_clk (ref_clk),
		.evt     (evt),
		.tec     (tec)
	);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] s);
		bus <= '{a, d, s, 1'b1, 1'b0};
		#1 ok_seen = timing_write_ok;
		@(posedge ref_clk);
		bus <= '0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [1:0] s, input logic [31:0] exp);
		bus <= '{a, 32'h0000_0000, s, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1 chk($sformatf("read %h", a), rdata, exp);
		@(posedge ref_clk);
	endtask : rd

	task automatic print_verdict();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	initial begin
		rst = 1'b1;
		bus = '0;
		status_ack = 1'b0;
		sleep_instruction = 1'b0;
		obj_rx_done = 15'h0000;
		obj_rx_len = 4'h0;
		rx_id = 29'h0000_0000;
		obj_id = 29'h0000_0000;
		tick(3);
		rst <= 1'b0;
		tick(1);
		#1 chk("isolated", bus_isolated, 32'h1);
		rd(16'h1E00, 2'h0, 32'h01);
		rd(16'h1E5F, 2'h0, 32'h00);
		wr(16'h1E3F, 32'h12, 2'h0);
		chk("timing ok", ok_seen, 32'h0);
		wr(16'h1E00, 32'hFF, 2'h0);
		rd(16'h1E00, 2'h0, 32'h4F);
		chk("unlock", timing_write_unlock, 32'h1);
		wr(16'h1E4F, 32'h34, 2'h0);
		chk("timing ok", ok_seen, 32'h1);
		wr(16'h1E08, 32'hFFFF_FFFF, 2'h2);
		rd(16'h1E08, 2'h2, 32'hF8FF_FFFF);
		wr(16'h1E08, 32'h0000_0001, 2'h2);
		chk("mask", id_match_mask, 32'h0020_0000);
		wr(16'h1E08, 32'h0800_0000, 2'h2);
		chk("mask", id_match_mask, 32'h1);
		wr(16'h1E0A, 32'h0000_0180, 2'h1);
		rd(16'h1E08, 2'h2, 32'h0080_0000);
		rd(16'h1E0A, 2'h1, 32'h0000_0080);
		chk("mask", id_match_mask, 32'h1000);
		obj_id <= 29'h0000_0001;
		#1 chk("accept", id_accept, 32'h1);
		obj_id <= 29'h0000_1000;
		#1 chk("accept", id_accept, 32'h0);
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		tick(1);
		rd(16'h1E08, 2'h2, 32'h0080_0000);
		for (int k = 2; k < 6; k++) begin
			wr(16'h1E00, 32'h03, 2'h0);
			i_ccir_node.pulse(k);
			rd(16'h1E5F, 2'h0, 32'h00);
			wr(16'h1E00, 32'h0F, 2'h0);
			i_ccir_node.pulse(k);
			rd(16'h1E5F, 2'h0, 32'h01);
			#1 chk("irq", irq, 32'h1);
			status_ack <= 1'b1;
			tick(1);
			status_ack <= 1'b0;
			tick(1);
			rd(16'h1E5F, 2'h0, 32'h00);
		end
		wr(16'h1E16, 32'h8F, 2'h0);
		rd(16'h1E16, 2'h0, 32'h8C);
		#1 chk("send", obj_is_send[0], 32'h1);
		chk("long", obj_long_id[0], 32'h1);
		for (int n = 1; n < 16; n++)
			wr(16'h1E10 + 16'(16 * (n - 1)), 32'hFB, 2'h0);
		obj_rx_len <= 4'h5;
		obj_rx_done <= 15'h7FFF;
		tick(1);
		obj_rx_done <= 15'h0000;
		tick(2);
		rd(16'h1E16, 2'h0, 32'h5C);
		rd(16'h1E10, 2'h0, 32'h5A);
		wr(16'h1E00, 32'h05, 2'h0);
		rd(16'h1E5F, 2'h0, 32'h02);
		#1 chk("irq", irq, 32'h0);
		wr(16'h1E00, 32'h07, 2'h0);
		wr(16'h1E5F, 32'hFF, 2'h0);
		#1 chk("irq", irq, 32'h1);
		// Clearing the top source each time walks the code down the priority list.
		for (int i = 0; i < 15; i++) begin
			rd(16'h1E5F, 2'h0, (i == 0) ? 32'h02 : 32'(i + 2));
			wr(16'h1E10 + 16'(16 * ((i == 0) ? 14 : i - 1)), 32'hFD, 2'h0);
		end
		rd(16'h1E5F, 2'h0, 32'h00);
		wr(16'h1E00, 32'h00, 2'h0);
		tick(1);
		i_ccir_node.bits(10, 1'b1);
		i_ccir_node.bits(1, 1'b0);
		i_ccir_node.bits(10, 1'b1);
		tick(1);
		#1 chk("start", start_allowed, 32'h0);
		i_ccir_node.bits(1, 1'b1);
		tick(1);
		#1 chk("start", start_allowed, 32'h1);
		sleep_instruction <= 1'b1;
		#1 chk("abort", send_abort, 32'h1);
		tick(1);
		sleep_instruction <= 1'b0;
		wr(16'h1E00, 32'h01, 2'h0);
		#1 chk("start", start_allowed, 32'h0);
		wr(16'h1E00, 32'h00, 2'h0);
		i_ccir_node.count(9'h100);
		tick(1);
		#1 chk("isolated", bus_isolated, 32'h1);
		i_ccir_node.count(9'h000);
		c0 = n_clear;
		wr(16'h1E00, 32'h00, 2'h0);
		i_ccir_node.bits(5, 1'b1);
		i_ccir_node.bits(1, 1'b0);
		i_ccir_node.bits(11 * 127 + 10, 1'b1);
		tick(1);
		#1 chk("start", start_allowed, 32'h0);
		i_ccir_node.bits(1, 1'b1);
		tick(1);
		#1 chk("start", start_allowed, 32'h1);
		chk("clears", 32'(n_clear - c0), 32'h1);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
